// [common/etm_map.svh]
`ifndef ETM_MAP_SVH
`define ETM_MAP_SVH
`define ETM_CUR_COUNT_OFS  4'h0
`define ETM_PREV_COUNT_OFS 4'h4
`define ETM_COUNT_RESET    32'h0000_0000
`define ETM_TS_RESET       32'h0000_0000
`define ETM_SW_ADDR_RESET  4'h0
`define ETM_PORT_MAX       63
`define ETM_PORT_DEFAULT   4
`define ETM_PIDX_W         6
`define ETM_TS_W           32
`define ETM_REC_W          40
`define ETM_SW_PORT        6'h3F
`endif

// [common/etm_pkg.sv]
package etm_pkg;
  typedef enum logic {
    ETM_EV_START,
    ETM_EV_STOP
  } etm_kind_type;
  typedef enum logic {
    ETM_MODE_BASIC,
    ETM_MODE_STATS
  } etm_mode_type;
endpackage

// [hdl/etm_trace_core.sv]
`timescale 1ns/1ps
`default_nettype none
`include "etm_map.svh"
module etm_trace_core
  import etm_pkg::*;
#(
  parameter int           NUM_ACCEL   = 1,
  parameter int           NUM_STREAM  = 3,
  parameter etm_mode_type STREAM_MODE = ETM_MODE_BASIC
) (
  input  wire logic                          ref_clk_i,
  input  wire logic                          resetn_i,
  // accelerator strobes
  input  wire logic [NUM_ACCEL-1:0]          accel_go_strobe_i,
  input  wire logic [NUM_ACCEL-1:0]          accel_finished_strobe_i,
  // observed streams
  input  wire logic [NUM_STREAM-1:0]         mon_tvalid_i,
  input  wire logic [NUM_STREAM-1:0]         mon_tready_i,
  input  wire logic [NUM_STREAM-1:0]         mon_tlast_i,
  // software event write
  input  wire logic                          sw_wvalid_i,
  input  wire logic                          sw_wdata_i,
  output logic                               sw_wready_o,
  // statistics read port, stream 0
  input  wire logic                          s_axil_arvalid_i,
  input  wire logic [3:0]                    s_axil_araddr_i,
  output logic                               s_axil_arready_o,
  output logic                               s_axil_rvalid_o,
  output logic [31:0]                        s_axil_rdata_o,
  output logic [1:0]                         s_axil_rresp_o,
  input  wire logic                          s_axil_rready_i,
  // trace stream to read-out
  output logic                               trace_tvalid_o,
  output logic [`ETM_REC_W-1:0]              trace_tdata_o,
  input  wire logic                          trace_tready_i,
  output logic                               trace_overflow_o
);
  localparam int NP = NUM_ACCEL + NUM_STREAM;
  localparam int NQ = NP + 1;

  // ---------------------------------------------------------------
  // global timer
  // ---------------------------------------------------------------
  logic [`ETM_TS_W-1:0] ts_reg;
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ts_reg <= `ETM_TS_RESET;
    end else begin
      ts_reg <= ts_reg + 32'h0000_0001;
    end
  end

  // ---------------------------------------------------------------
  // monitors
  // ---------------------------------------------------------------
  logic [NQ-1:0] ev_start;
  logic [NQ-1:0] ev_stop;
  logic [NUM_STREAM-1:0] in_xfer_reg;

  genvar g;
  generate
    for (g = 0; g < NUM_ACCEL; g++) begin : g_acc
      assign ev_start[g] = accel_go_strobe_i[g];
      assign ev_stop[g]  = accel_finished_strobe_i[g];
    end
    for (g = 0; g < NUM_STREAM; g++) begin : g_str
      logic hs;
      assign hs = mon_tvalid_i[g] & mon_tready_i[g];
      assign ev_start[NUM_ACCEL+g] = hs & ~in_xfer_reg[g];
      assign ev_stop[NUM_ACCEL+g]  = hs & mon_tlast_i[g];
      always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          in_xfer_reg[g] <= 1'b0;
        end else if (hs) begin
          in_xfer_reg[g] <= ~mon_tlast_i[g];
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // software events
  // ---------------------------------------------------------------
  // one write per event
  assign sw_wready_o = 1'b1;
  assign ev_start[NP] = sw_wvalid_i & ~sw_wdata_i;
  assign ev_stop[NP]  = sw_wvalid_i & sw_wdata_i;

  // ---------------------------------------------------------------
  // statistics on stream 0
  // ---------------------------------------------------------------
  logic [31:0] cur_cnt_reg;
  logic [31:0] prev_cnt_reg;
  logic        s0_hs;
  assign s0_hs = mon_tvalid_i[0] & mon_tready_i[0];

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cur_cnt_reg <= `ETM_COUNT_RESET;
    end else if (s0_hs) begin
      if (mon_tlast_i[0]) begin
        cur_cnt_reg <= `ETM_COUNT_RESET;
      end else begin
        cur_cnt_reg <= cur_cnt_reg + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      prev_cnt_reg <= `ETM_COUNT_RESET;
    end else if (s0_hs && mon_tlast_i[0]) begin
      prev_cnt_reg <= cur_cnt_reg + 32'h0000_0001;
    end
  end

  // ---------------------------------------------------------------
  // statistics read channel
  // ---------------------------------------------------------------
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0]  rresp_reg;
  logic        stats_en;
  logic        rd_take;
  assign stats_en = (STREAM_MODE == ETM_MODE_STATS);
  assign rd_take  = s_axil_arvalid_i & s_axil_arready_o;
  assign s_axil_arready_o = stats_en & ~rvalid_reg;
  assign s_axil_rvalid_o  = rvalid_reg;
  assign s_axil_rdata_o   = rdata_reg;
  assign s_axil_rresp_o   = rresp_reg;

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rvalid_reg <= 1'b0;
    end else if (rd_take) begin
      rvalid_reg <= 1'b1;
    end else if (s_axil_rready_i) begin
      rvalid_reg <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_reg <= `ETM_COUNT_RESET;
      rresp_reg <= 2'h0;
    end else if (rd_take) begin
      unique case (s_axil_araddr_i)
        `ETM_CUR_COUNT_OFS: begin
          rdata_reg <= cur_cnt_reg;
          rresp_reg <= 2'h0;
        end
        `ETM_PREV_COUNT_OFS: begin
          rdata_reg <= prev_cnt_reg;
          rresp_reg <= 2'h0;
        end
        default: begin
          rdata_reg <= `ETM_COUNT_RESET;
          rresp_reg <= 2'h2;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // merge: pending events latched with timestamp
  // ---------------------------------------------------------------
  logic [NQ-1:0]        pend_reg;
  logic [NQ-1:0]        pkind_reg;
  logic [`ETM_TS_W-1:0] pts_reg [NQ];
  logic [NQ-1:0]        grant;
  logic                 mrg_valid;
  logic                 mrg_ready;
  logic [`ETM_REC_W-1:0] mrg_rec;
  logic                 lost_reg;

  function automatic logic [`ETM_PIDX_W-1:0] port_id(input int p);
    port_id = (p == NP) ? `ETM_SW_PORT : p[`ETM_PIDX_W-1:0];
  endfunction

  always_comb begin
    grant   = '0;
    mrg_rec = '0;
    for (int p = 0; p < NQ; p++) begin
      if (pend_reg[p] && grant == '0) begin
        grant[p] = 1'b1;
        mrg_rec  = {1'b0, port_id(p), pkind_reg[p], pts_reg[p]};
      end
    end
  end
  assign mrg_valid = |pend_reg;

  generate
    for (g = 0; g < NQ; g++) begin : g_q
      logic take;
      logic hit;
      assign take = grant[g] & mrg_ready;
      assign hit  = (ev_start[g] | ev_stop[g]) & (~pend_reg[g] | take);
      always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          pend_reg[g] <= 1'b0;
        end else if (hit) begin
          pend_reg[g] <= 1'b1;
        end else if (take) begin
          pend_reg[g] <= 1'b0;
        end
      end
      always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          pkind_reg[g] <= 1'b0;
          pts_reg[g]   <= `ETM_TS_RESET;
        end else if (hit) begin
          pkind_reg[g] <= ev_stop[g];
          pts_reg[g]   <= ts_reg;
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // sticky overflow flag
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      lost_reg <= 1'b0;
    end else if (|((ev_start | ev_stop) & pend_reg & ~(grant & {NQ{mrg_ready}})))
    begin
      lost_reg <= 1'b1;
    end
  end
  assign trace_overflow_o = lost_reg;

  // ---------------------------------------------------------------
  // two-entry trace buffer
  // ---------------------------------------------------------------
  logic [`ETM_REC_W-1:0] buf_reg [2];
  logic                  wptr_reg;
  logic                  rptr_reg;
  logic [1:0]            cnt_reg;
  logic                  push;
  logic                  pop;

  assign mrg_ready      = (cnt_reg != 2'h2);
  assign push           = mrg_valid & mrg_ready;
  assign trace_tvalid_o = (cnt_reg != 2'h0);
  assign pop            = trace_tvalid_o & trace_tready_i;
  assign trace_tdata_o  = buf_reg[rptr_reg];

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      buf_reg[0] <= '0;
      buf_reg[1] <= '0;
    end else if (push) begin
      buf_reg[wptr_reg] <= mrg_rec;
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wptr_reg <= 1'b0;
    end else if (push) begin
      wptr_reg <= ~wptr_reg;
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rptr_reg <= 1'b0;
    end else if (pop) begin
      rptr_reg <= ~rptr_reg;
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_reg <= 2'h0;
    end else begin
      cnt_reg <= cnt_reg + {1'b0, push} - {1'b0, pop};
    end
  end

endmodule // etm_trace_core
`default_nettype wire

// [verif/etm_trace_core_properties.sv]
`timescale 1ns/1ps
`default_nettype none
// ------
// checker
// ------
module etm_trace_core_properties #(
  parameter int NUM_ACCEL  = 1,
  parameter int NUM_STREAM = 3
) (
  input wire logic                  ref_clk_i,
  input wire logic                  resetn_i,
  input wire logic [NUM_ACCEL-1:0]  accel_go_strobe_i,
  input wire logic [NUM_ACCEL-1:0]  accel_finished_strobe_i,
  input wire logic [NUM_STREAM-1:0] mon_tvalid_i,
  input wire logic                  sw_wvalid_i,
  input wire logic                  sw_wdata_i,
  input wire logic                  sw_wready_o,
  input wire logic                  s_axil_arvalid_i,
  input wire logic [3:0]            s_axil_araddr_i,
  input wire logic                  s_axil_arready_o,
  input wire logic                  s_axil_rvalid_o,
  input wire logic [31:0]           s_axil_rdata_o,
  input wire logic [1:0]            s_axil_rresp_o,
  input wire logic                  s_axil_rready_i,
  input wire logic                  trace_tvalid_o,
  input wire logic [39:0]           trace_tdata_o,
  input wire logic                  trace_tready_i,
  input wire logic                  trace_overflow_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  logic [31:0] ts_reg;
  wire logic hw = |accel_go_strobe_i | |accel_finished_strobe_i | |mon_tvalid_i;
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) ts_reg <= 32'h0;
    else ts_reg <= ts_reg + 32'h1;
  end
  property p_swr; sw_wready_o; endproperty
  a_swr: assert property (p_swr) else $error("sw ready low");
  property p_rd; s_axil_arvalid_i && s_axil_arready_o |=> s_axil_rvalid_o;
  endproperty
  a_rd: assert property (p_rd) else $error("no read answer");
  property p_rhold; s_axil_rvalid_o && !s_axil_rready_i |=>
    s_axil_rvalid_o && $stable(s_axil_rdata_o); endproperty
  a_rhold: assert property (p_rhold) else $error("read dropped");
  property p_bad; s_axil_arvalid_i && s_axil_arready_o && s_axil_araddr_i[3]
    |=> s_axil_rresp_o == 2'h2 && s_axil_rdata_o == 32'h0; endproperty
  a_bad: assert property (p_bad) else $error("bad addr answer");
  property p_thold; trace_tvalid_o && !trace_tready_i |=>
    trace_tvalid_o && $stable(trace_tdata_o); endproperty
  a_thold: assert property (p_thold) else $error("record dropped");
  property p_ovf; trace_overflow_o |=> trace_overflow_o; endproperty
  a_ovf: assert property (p_ovf) else $error("overflow cleared");
  property p_go; !(hw | sw_wvalid_i) ##1 accel_go_strobe_i[0] && !trace_tvalid_o
    |-> ##2 trace_tvalid_o && trace_tdata_o == {8'h00, $past(ts_reg, 2)};
  endproperty
  a_go: assert property (p_go) else $error("go record");
  property p_sw; !(hw | sw_wvalid_i) ##1 sw_wvalid_i && !hw && !trace_tvalid_o
    |-> ##2 trace_tvalid_o && trace_tdata_o ==
    {1'b0, 6'h3F, $past(sw_wdata_i, 2), $past(ts_reg, 2)}; endproperty
  a_sw: assert property (p_sw) else $error("sw record");
endmodule // etm_trace_core_properties
bind etm_trace_core etm_trace_core_properties #(.NUM_ACCEL(NUM_ACCEL),
  .NUM_STREAM(NUM_STREAM)) u_props (.ref_clk_i(ref_clk_i),
  .resetn_i(resetn_i), .accel_go_strobe_i(accel_go_strobe_i),
  .accel_finished_strobe_i(accel_finished_strobe_i),
  .mon_tvalid_i(mon_tvalid_i), .sw_wvalid_i(sw_wvalid_i),
  .sw_wdata_i(sw_wdata_i), .sw_wready_o(sw_wready_o),
  .s_axil_arvalid_i(s_axil_arvalid_i), .s_axil_araddr_i(s_axil_araddr_i),
  .s_axil_arready_o(s_axil_arready_o), .s_axil_rvalid_o(s_axil_rvalid_o),
  .s_axil_rdata_o(s_axil_rdata_o), .s_axil_rresp_o(s_axil_rresp_o),
  .s_axil_rready_i(s_axil_rready_i), .trace_tvalid_o(trace_tvalid_o),
  .trace_tdata_o(trace_tdata_o), .trace_tready_i(trace_tready_i),
  .trace_overflow_o(trace_overflow_o));
`default_nettype wire

// [verif/etm_stream_src.sv]
`timescale 1ns/1ps
`default_nettype none
// ------
// stream link model
// ------
module etm_stream_src (
  input  wire logic       ref_clk_i,
  input  wire logic       resetn_i,
  input  wire logic       start_i,
  input  wire logic [3:0] len_i,
  input  wire logic       last_i,
  output logic            tvalid_o,
  output logic            tready_o,
  output logic            tlast_o
);
  logic [3:0] cnt_reg;
  logic       ph_reg;
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_reg <= 4'h0;
      ph_reg  <= 1'b0;
    end else begin
      ph_reg <= ~ph_reg;
      if (start_i) cnt_reg <= len_i;
      else if (tvalid_o && tready_o) cnt_reg <= cnt_reg - 4'h1;
    end
  end
  assign tvalid_o = cnt_reg != 4'h0;
  assign tready_o = ph_reg; // stalls every other cycle
  assign tlast_o  = tvalid_o ? (last_i && cnt_reg == 4'h1) : ph_reg;
endmodule // etm_stream_src
`default_nettype wire

// [verif/tb_etm_trace_core.sv]
`timescale 1ns/1ps
`default_nettype none
// ------
// bench
// ------
module tb_etm_trace_core;
  import etm_pkg::*;
  logic clk = 1'b0, rstn = 1'b0, go = 1'b0, fin = 1'b0, sv = 1'b0, sd = 1'b0;
  logic av = 1'b0, rr = 1'b0, tr = 1'b1, ps = 1'b0, pl = 1'b0;
  logic [3:0] aa = 4'h0, pn = 4'h0;
  wire logic swr, ar, rv, tv, ov, pv, pr, pt, arb;
  wire logic [31:0] rdat;
  wire logic [1:0] rs;
  wire logic [39:0] td;
  int num_errors = 0, tests_run = 0, cyc = 0;
  etm_trace_core #(.STREAM_MODE(ETM_MODE_STATS)) DUT (.ref_clk_i(clk),
    .resetn_i(rstn), .accel_go_strobe_i(go), .accel_finished_strobe_i(fin),
    .mon_tvalid_i({2'h0, pv}), .mon_tready_i({2'h0, pr}),
    .mon_tlast_i({2'h0, pt}), .sw_wvalid_i(sv), .sw_wdata_i(sd),
    .sw_wready_o(swr), .s_axil_arvalid_i(av), .s_axil_araddr_i(aa),
    .s_axil_arready_o(ar), .s_axil_rvalid_o(rv), .s_axil_rdata_o(rdat),
    .s_axil_rresp_o(rs), .s_axil_rready_i(rr), .trace_tvalid_o(tv),
    .trace_tdata_o(td), .trace_tready_i(tr), .trace_overflow_o(ov));
  etm_trace_core u_basic (.ref_clk_i(clk),
    .resetn_i(rstn), .accel_go_strobe_i(go), .accel_finished_strobe_i(fin),
    .mon_tvalid_i({2'h0, pv}), .mon_tready_i({2'h0, pr}),
    .mon_tlast_i({2'h0, pt}), .sw_wvalid_i(sv), .sw_wdata_i(sd),
    .sw_wready_o(), .s_axil_arvalid_i(av), .s_axil_araddr_i(aa),
    .s_axil_arready_o(arb), .s_axil_rvalid_o(), .s_axil_rdata_o(),
    .s_axil_rresp_o(), .s_axil_rready_i(rr), .trace_tvalid_o(),
    .trace_tdata_o(), .trace_tready_i(tr), .trace_overflow_o());
  etm_stream_src u_src (.ref_clk_i(clk), .resetn_i(rstn), .start_i(ps),
    .len_i(pn), .last_i(pl), .tvalid_o(pv), .tready_o(pr), .tlast_o(pt));
  initial forever #2 clk = ~clk;
  task test_done;
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      num_errors++;
      test_done;
    end
  end
  task chk(input bit ok, input string m);
    tests_run++;
    if (!ok) begin
      num_errors++;
      $display("Error %0t: %s", $time, m);
    end
  endtask
  task ev(input logic [5:0] i, input logic s);
    do @(posedge clk); while (tv !== 1'b1);
    chk(td[39:32] === {1'b0, i, s}, "record");
  endtask
  task rd(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
    av <= 1'b1;
    aa <= a;
    rr <= 1'b0;
    do @(posedge clk); while (ar !== 1'b1);
    chk(arb === 1'b0, "basic ready");
    av <= 1'b0;
    do @(posedge clk); while (rv !== 1'b1);
    rr <= 1'b1;
    @(posedge clk);
    chk(rdat === d && rs === r, "read");
  endtask
  task pulse(input logic g, input logic f, input logic s, input logic d);
    go <= g;
    fin <= f;
    sv <= s;
    sd <= d;
    @(posedge clk);
    go <= 1'b0;
    fin <= 1'b0;
    sv <= 1'b0;
  endtask
  task str(input logic [3:0] n, input logic l);
    ps <= 1'b1;
    pn <= n;
    pl <= l;
    @(posedge clk);
    ps <= 1'b0;
    do @(posedge clk); while (pv === 1'b1);
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    pulse(1, 0, 0, 0); ev(6'h00, 0);
    pulse(0, 1, 0, 0); ev(6'h00, 1);
    $display("test accel done");
    fork str(4'h3, 0); ev(6'h01, 0); join
    rd(4'h0, 32'h3, 2'h0);
    fork str(4'h2, 1); ev(6'h01, 1); join
    rd(4'h4, 32'h5, 2'h0);
    rd(4'h0, 32'h0, 2'h0);
    rd(4'h8, 32'h0, 2'h2);
    $display("test stream done");
    for (int d = 0; d < 2; d++) begin
      pulse(0, 0, 1, d[0]); ev(6'h3F, d[0]);
      chk(swr === 1'b1, "sw ready");
    end
    pulse(1, 0, 1, 0); ev(6'h00, 0); ev(6'h3F, 0);
    $display("test merge done");
    tr <= 1'b0;
    go <= 1'b1;
    repeat (4) @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    chk(ov === 1'b1, "overflow");
    tr <= 1'b1;
    repeat (3) ev(6'h00, 0);
    repeat (2) @(posedge clk);
    chk(tv === 1'b0 && ov === 1'b1, "drain");
    $display("test buffer done");
    test_done;
  end
endmodule // tb_etm_trace_core
`default_nettype wire
